// ===== logic/gfm_defines.svh
// gfm_defines.svh: offsets, field positions, reset values and timing counts
// of the fault monitor. Assumes a 200 MHz SYS_CLK and a 32-bit SPI frame.
// Summary of operation
// - fault flags latch on detection and hold until the host reads them
// - a still-present condition re-sets its flag at once after the clearing read; checksum and volatile-copy flags at their next check
// - summary fault byte rides in every sensor data response
// - read of address 0x0A returns the detail byte with the summary byte
// - active clock-lock-loss flag makes sensor data status 00 unless check bit is set
// - quadrature level above 4096 LSB raises the quadrature flag
// - quadrature correction accumulator reaching 4 deg/s equivalent raises quadrature flag
// - nonvolatile checksum every 50 us, identifier excluded, sets checksum flag
// - volatile copy checked against ROM constant every 1 us
// - regulation flag follows high or low supply condition
// - filtered supply above 3.3 V sets the high supply flag
// - filtered supply below 2.77 V sets the low supply flag
// - self-test deviation beyond 320 LSB sets the self-test flag
// - self-test deviation beyond 1280 LSB also forces status 00 unless check bit is set
// - check bit forces every fault, all visible within 50 ms
// - while check bit is set, sensor data status is 10
// - forced faults linger up to 50 ms after check bit clears
// - gross-failure flag set whenever status would be 00
// - summary self-test position in sensor data responses carries amplitude OR self-test fault
// - check mode shifts self-test amplitude past the threshold
// - status codes: 00 error, 01 valid, 10 self-test, 11 read/write
`ifndef GFM_DEFINES_SVH
`define GFM_DEFINES_SVH
`define GFM_SYS_MHZ 200
`define GFM_NVM_PERIOD_US 50
`define GFM_NVM_CYC (`GFM_NVM_PERIOD_US * `GFM_SYS_MHZ)
`define GFM_POR_PERIOD_US 1
`define GFM_POR_CYC (`GFM_POR_PERIOD_US * `GFM_SYS_MHZ)
`define GFM_DECAY_MS 50
`define GFM_DECAY_CYC (`GFM_DECAY_MS * 1000 * `GFM_SYS_MHZ)
`define GFM_ADDR_QUAD 9'h008
`define GFM_ADDR_FAULT 9'h00A
`define GFM_QUAD_LIM 16'h1000
`define GFM_QACC_DPS 4
`define GFM_RATE_SCALE 80
`define GFM_QACC_LIM (`GFM_QACC_DPS * `GFM_RATE_SCALE)
`define GFM_OV_MV 12'hCE4
`define GFM_UV_MV 12'hAD2
`define GFM_FILT_RST 16'hBB80
`define GFM_CST_LIM 17'h00140
`define GFM_GROSS_LIM 17'h00500
`define GFM_ST_ERR 2'h0
`define GFM_ST_VALID 2'h1
`define GFM_ST_SELF 2'h2
`define GFM_ST_RW 2'h3
`define GFM_CHK_BIT 1
`define GFM_FL_PLL 0
`define GFM_FL_Q 1
`define GFM_FL_NVM 2
`define GFM_FL_POR 3
`define GFM_FL_PWR 4
`define GFM_FL_CST 5
`define GFM_FL_FAIL 6
`define GFM_FL_AMP 7
`define GFM_FL_OV 8
`define GFM_FL_UV 9
`endif

// ===== logic/gfm_pkg.sv
// gfm_pkg.sv: types of the fault monitor.
// Assumes gfm_defines.svh for all numeric constants.
package gfm_pkg;
  typedef enum logic [3:0] {
    GFM_CMD_SENSOR = 4'h1,
    GFM_CMD_READ = 4'h2,
    GFM_CMD_WRITE = 4'h4,
    GFM_CMD_BAD = 4'h8
  } gfm_cmd_t;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic s3;
    logic [9:0] fl;
    logic chk;
    logic [23:0] dcnt;
    logic [13:0] ncnt;
    logic [7:0] pcnt;
    logic [15:0] filt;
    logic [23:0] qacc;
    logic [15:0] vcopy;
    logic [31:0] resp;
  } gfm_sys_t;
  typedef struct packed {
    logic [30:0] rx;
    logic [30:0] tx;
    logic [31:0] cmd;
    logic tgl;
  } gfm_lnk_t;
endpackage

// ===== logic/gfm_fault_monitor.sv
// gfm_fault_monitor.sv: sticky fault flags, check mode and SPI response build.
// Assumes SPI mode 0 from the host; detector levels PLL_UNLOCK/AMP_LOW are
// asynchronous, the remaining measurement buses come from SYS_CLK logic.
`timescale 1ns/1ps
`include "gfm_defines.svh"
module gfm_fault_monitor
  import gfm_pkg::*;
#(
  parameter int NVM_BYTES = 8,
  parameter logic [15:0] ROM_WORD = 16'hA5C3, // arbitrary
  parameter logic [15:0] ST_NOMINAL = 16'h0000,
  parameter logic [15:0] ST_SHIFT = 16'h0800,
  parameter int NVM_CYC = `GFM_NVM_CYC,
  parameter int DECAY_CYC = `GFM_DECAY_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  input wire logic PLL_UNLOCK,
  input wire logic AMP_LOW,
  input wire logic [15:0] RATE_DATA,
  input wire logic [15:0] QUAD_LEVEL,
  input wire logic [15:0] QUAD_CORR,
  input wire logic QUAD_CORR_VALID,
  input wire logic [NVM_BYTES*8-1:0] NVM_IMAGE,
  input wire logic [11:0] SUPPLY_MV,
  input wire logic [15:0] ST_VALUE,
  output logic CHECK_MODE
);

  function automatic gfm_cmd_t decode(input logic [31:0] c);
    if (c[29]) return GFM_CMD_SENSOR;
    if (c[31:29] == 3'h4) return GFM_CMD_READ;
    if (c[31:29] == 3'h2) return GFM_CMD_WRITE;
    return GFM_CMD_BAD;
  endfunction

  // byte sum of the image must be zero; identifier bytes are not in it
  function automatic logic csum_ok(input logic [NVM_BYTES*8-1:0] img);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < NVM_BYTES; i++) begin
      s = s + img[i*8 +: 8];
    end
    return s == 8'h00;
  endfunction

  function automatic logic [15:0] mag16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  gfm_sys_t q, d;
  gfm_lnk_t lq, ld;
  logic [5:0] cnt_q;

  // ---------------- link domain (SCLK) ----------------
  // counter dies with the frame; CS_N high holds it at zero
  always_ff @(posedge SCLK or posedge CS_N or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 6'h00;
    end else if (CS_N) begin
      cnt_q <= 6'h00;
    end else if (cnt_q != 6'h20) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // q.resp is stable here: it changes only a few SYS_CLK cycles after the
  // previous frame, well inside the required gap between frames
  always_comb begin
    ld = lq;
    ld.rx = {lq.rx[29:0], MOSI};
    ld.tx = (cnt_q == 6'h00) ? q.resp[30:0] : {lq.tx[29:0], 1'b0};
    if (cnt_q == 6'h1F) begin
      ld.cmd = {lq.rx, MOSI};
      ld.tgl = ~lq.tgl;
    end
  end

  always_ff @(posedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  assign MISO = (cnt_q == 6'h00) ? q.resp[31] : lq.tx[30];
  assign MISO_OE = ~CS_N;

  // ---------------- system domain ----------------
  logic ev, force_w, gross, st_err;
  logic nvm_tick, por_tick;
  logic is_sensor, rd_fault;
  logic [9:0] det, clr;
  logic [16:0] st_eff, st_dev, st_mag;
  logic [23:0] qacc_mag;
  logic [16:0] filt_sum;
  logic c_ov, c_uv;
  logic [7:0] summ;
  logic [15:0] rdata;
  logic [31:0] r;
  gfm_cmd_t kind;

  assign ev = q.s2[2] ^ q.s3;
  assign kind = decode(lq.cmd);
  assign is_sensor = ev && (kind == GFM_CMD_SENSOR);
  assign rd_fault = ev && (kind == GFM_CMD_READ) && (lq.cmd[25:17] == `GFM_ADDR_FAULT);
  assign force_w = q.chk || (q.dcnt != 24'h000000);
  assign nvm_tick = (q.ncnt == 14'(NVM_CYC - 1));
  assign por_tick = (q.pcnt == 8'(`GFM_POR_CYC - 1));
  assign st_eff = {ST_VALUE[15], ST_VALUE} + (force_w ? {1'b0, ST_SHIFT} : 17'h00000);
  assign st_dev = st_eff - {ST_NOMINAL[15], ST_NOMINAL};
  assign st_mag = st_dev[16] ? 17'(-st_dev) : st_dev;
  assign gross = st_mag > `GFM_GROSS_LIM;
  assign qacc_mag = q.qacc[23] ? 24'(-q.qacc) : q.qacc;
  assign c_ov = (q.filt[15:4] > `GFM_OV_MV) || force_w;
  assign c_uv = (q.filt[15:4] < `GFM_UV_MV) || force_w;
  assign st_err = q.fl[`GFM_FL_PLL] || gross;
  assign filt_sum = {1'b0, q.filt} + {5'h00, SUPPLY_MV} - {5'h00, q.filt[15:4]};

  always_comb begin
    det = 10'h000;
    det[`GFM_FL_PLL] = q.s2[0] || force_w;
    det[`GFM_FL_Q] = (mag16(QUAD_LEVEL) > `GFM_QUAD_LIM)
      || (qacc_mag >= 24'(`GFM_QACC_LIM)) || force_w;
    det[`GFM_FL_NVM] = (nvm_tick && !csum_ok(NVM_IMAGE)) || force_w;
    det[`GFM_FL_POR] = (por_tick && (q.vcopy != ROM_WORD)) || force_w;
    det[`GFM_FL_PWR] = c_ov || c_uv;
    det[`GFM_FL_CST] = st_mag > `GFM_CST_LIM;
    det[`GFM_FL_FAIL] = st_err || force_w;
    det[`GFM_FL_AMP] = q.s2[1] || force_w;
    det[`GFM_FL_OV] = c_ov;
    det[`GFM_FL_UV] = c_uv;
  end

  // sensor responses clear the summary byte, the 0x0A read clears both
  always_comb begin
    clr = 10'h000;
    if (is_sensor) begin
      clr[5:0] = 6'h3F;
    end
    if (rd_fault) begin
      clr = 10'h3FF;
    end
  end

  assign summ = {q.fl[`GFM_FL_PLL], q.fl[`GFM_FL_Q], q.fl[`GFM_FL_NVM], q.fl[`GFM_FL_POR],
    q.fl[`GFM_FL_PWR], q.fl[`GFM_FL_CST], q.chk, 1'b0};

  always_comb begin
    rdata = 16'h0000;
    if (lq.cmd[25:17] == `GFM_ADDR_QUAD) begin
      rdata = QUAD_LEVEL;
    end else if (lq.cmd[25:17] == `GFM_ADDR_FAULT) begin
      rdata = {4'h0, q.fl[`GFM_FL_FAIL], q.fl[`GFM_FL_AMP], q.fl[`GFM_FL_OV],
        q.fl[`GFM_FL_UV], summ};
    end
  end

  always_comb begin
    r = 32'h00000000;
    unique case (kind)
      GFM_CMD_SENSOR: begin
        r = {lq.cmd[28], lq.cmd[31:30], 1'b0, 2'h0, RATE_DATA, 2'h0, summ[7:1], 1'b0};
        r[2] = summ[2] || q.fl[`GFM_FL_AMP];
        if (q.chk) begin
          r[27:26] = `GFM_ST_SELF;
        end else if (st_err) begin
          r[27:26] = `GFM_ST_ERR;
        end else begin
          r[27:26] = `GFM_ST_VALID;
        end
      end
      GFM_CMD_READ: begin
        r = {3'h2, 1'b0, `GFM_ST_RW, 2'h2, 3'h0, rdata, 5'h00};
      end
      GFM_CMD_WRITE: begin
        r = {3'h1, 1'b0, `GFM_ST_RW, 2'h2, 3'h0, lq.cmd[16:1], 5'h00};
      end
      GFM_CMD_BAD: begin
        r = {3'h0, 1'b0, `GFM_ST_RW, 2'h2, 3'h0, 5'h02, 8'h7F, summ[7:1], 1'b0};
      end
    endcase
    r[28] = ~^r[31:16];
    r[0] = ~^r[31:1];
  end

  always_comb begin
    d = q;
    d.s1 = {lq.tgl, AMP_LOW, PLL_UNLOCK};
    d.s2 = q.s1;
    d.s3 = q.s2[2];
    // set wins over the clearing read
    for (int i = 0; i < 10; i++) begin
      d.fl[i] = (q.fl[i] && !clr[i]) || det[i];
    end
    if (is_sensor) begin
      d.chk = lq.cmd[`GFM_CHK_BIT];
    end
    if (q.chk && !d.chk) begin
      d.dcnt = 24'(DECAY_CYC - 1);
    end else if (q.dcnt != 24'h000000) begin
      d.dcnt = q.dcnt - 24'h000001;
    end
    d.ncnt = nvm_tick ? 14'h0000 : q.ncnt + 14'h0001;
    d.pcnt = por_tick ? 8'h00 : q.pcnt + 8'h01;
    d.filt = filt_sum[15:0];
    // accumulator is not saturated; 24 bits outlast the fault threshold
    if (QUAD_CORR_VALID) begin
      d.qacc = q.qacc + {{8{QUAD_CORR[15]}}, QUAD_CORR};
    end
    if (ev) begin
      d.resp = r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.filt <= `GFM_FILT_RST;
      q.vcopy <= ROM_WORD;
      q.resp <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  assign CHECK_MODE = q.chk;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  a_flag_sticky: assert property (q.fl[`GFM_FL_Q] && !is_sensor && !rd_fault |=> q.fl[`GFM_FL_Q])
    else $error("quadrature flag dropped without a read");
  a_flag_reassert: assert property (rd_fault && det[`GFM_FL_UV] |=> q.fl[`GFM_FL_UV] ##1 q.fl[`GFM_FL_UV])
    else $error("persisting fault not re-set after read");
  a_pwr_follows: assert property ((c_ov || c_uv) |=> q.fl[`GFM_FL_PWR])
    else $error("regulation flag missing");
  a_quad_limit: assert property (mag16(QUAD_LEVEL) > `GFM_QUAD_LIM |=> q.fl[`GFM_FL_Q])
    else $error("quadrature level fault missing");
  a_chk_status: assert property (is_sensor && q.chk |=> q.resp[27:26] == 2'h2)
    else $error("check mode status not 10");
  a_err_status: assert property (is_sensor && !q.chk && st_err |=> q.resp[27:26] == 2'h0)
    else $error("error status not 00");
  a_fail_flag: assert property (st_err |=> q.fl[`GFM_FL_FAIL])
    else $error("gross failure flag missing");
  a_force_all: assert property ($rose(q.chk) |-> ##[1:3] (&q.fl))
    else $error("check mode did not raise all flags");
  a_decay_hold: assert property ($fell(q.chk) |-> force_w[*8])
    else $error("forced faults released too early");
  a_summary_or: assert property (is_sensor |=> q.resp[2] == $past(q.fl[`GFM_FL_CST] || q.fl[`GFM_FL_AMP]))
    else $error("self-test position not amp or cst");

endmodule // gfm_fault_monitor

// ===== dv/gfm_host_model.sv
// gfm_host_model.sv: SPI host that frames 32-bit commands, MSB first.
// Assumes mode 0 and a device that shifts MISO after each SCLK rise.
`timescale 1ns/1ps
module gfm_host_model (
  output logic SCLK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // 6 ns link clock, still outside frames
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    #1.7 CS_N = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      MOSI = cmd[i];
      #3 rsp[i] = MISO;
      SCLK = 1'b1;
      #3 SCLK = 1'b0;
    end
    #3 CS_N = 1'b1;
    MOSI = ~MOSI; // released line must not look stale
    #120; // frames far apart compared to the device, fault reads often
  endtask
endmodule // gfm_host_model

// ===== dv/tb.sv
// tb.sv: fault monitor bench, sequences of SPI frames with expected values.
// Assumes gfm_host_model as the SPI host and shortened timing counts.
`timescale 1ns/1ps
`include "gfm_defines.svh"
module tb;
  logic clk, rstn, pll, resonator_level_flag, qv, cm, sclk, cs_n, mosi, miso, oe;
  logic [15:0] ql, qc, stv;
  logic [11:0] mv;
  logic [63:0] checksum_fault_flag;
  logic [31:0] rsp;
  int miscompares, compares;
  initial begin
    clk = 1'b0; rstn = 1'b0; pll = 1'b0; resonator_level_flag = 1'b0; qv = 1'b0;
    ql = 16'h0000; qc = 16'h0000; stv = 16'h0000; mv = 12'hBB8; checksum_fault_flag = 64'h0;
  end
  always #2.5 clk = ~clk;
  gfm_host_model u_host (.SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso));
  gfm_fault_monitor #(.NVM_CYC(64), .DECAY_CYC(32)) u_dut (.SYS_CLK(clk), .RESETN(rstn), .SCLK(sclk),
    .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(oe), .PLL_UNLOCK(pll), .AMP_LOW(resonator_level_flag), .RATE_DATA(16'h1234),
    .QUAD_LEVEL(ql), .QUAD_CORR(qc), .QUAD_CORR_VALID(qv), .NVM_IMAGE(checksum_fault_flag), .SUPPLY_MV(mv), .ST_VALUE(stv),
    .CHECK_MODE(cm));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_st(input logic [1:0] e); cmp("status", {14'h0, e}, {14'h0, rsp[27:26]}); endtask
  task automatic chk_fl(input logic [6:0] e); cmp("summary", {9'h0, e}, {9'h0, rsp[7:1]}); endtask
  task automatic chk_d(input logic [11:0] e); cmp("detail", {4'h0, e}, rsp[20:5]); endtask
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  task automatic sens(input logic c); u_host.xfer({3'b001, 27'h0, c, c}, rsp); endtask
  task automatic rd; u_host.xfer({3'b100, 3'b000, `GFM_ADDR_FAULT, 17'h0}, rsp); endtask
  // answer lags one frame, so the second frame shows the state at the first
  task automatic state(input logic c); sens(c); sens(c); endtask
  task automatic corr; @(posedge clk); qc <= 16'h0050; qv <= 1'b1; @(posedge clk); qv <= 1'b0; endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(5); rstn <= 1'b1; cyc(4);
    cmp("output enable", 16'h0000, {15'h0, oe});
    state(0); chk_st(2'b01); chk_fl(7'h00);
    cmp("rate", 16'h1234, rsp[25:10]);
    $display("test clean done");
    pll <= 1'b1; cyc(4); pll <= 1'b0; cyc(10);
    sens(0); rd; chk_st(2'b00); chk_fl(7'h40);
    sens(0); chk_d(12'h800);
    state(0); chk_st(2'b01); chk_fl(7'h00);
    $display("test lock loss done");
    for (int i = 0; i < 2; i++) begin
      ql <= i ? 16'hEFFF : 16'h1001; cyc(10);
      state(0); chk_fl(7'h20);
      sens(0); chk_fl(7'h20);
    end
    ql <= 16'h1000; cyc(10); sens(0); state(0); chk_fl(7'h00);
    u_host.xfer({3'b100, 3'b000, `GFM_ADDR_QUAD, 17'h0}, rsp); sens(0);
    cmp("quad level", 16'h1000, rsp[20:5]);
    chk_st(2'b11);
    checksum_fault_flag <= 64'h1; cyc(80); state(0); chk_fl(7'h10);
    checksum_fault_flag <= 64'h0; cyc(80); state(0); state(0); chk_fl(7'h00);
    $display("test quad and checksum done");
    for (int i = 0; i < 2; i++) begin
      mv <= i ? 12'hA8C : 12'hD48; cyc(200);
      state(0); chk_fl(7'h04);
      rd; sens(0); chk_d(i ? 12'h108 : 12'h208);
      mv <= 12'hBB8; cyc(200); rd; state(0);
    end
    $display("test supply done");
    stv <= 16'h0190; cyc(10); state(0); chk_st(2'b01); chk_fl(7'h02);
    stv <= 16'h0514; cyc(10); state(0); chk_st(2'b00); chk_fl(7'h02);
    stv <= 16'h0000; resonator_level_flag <= 1'b1; cyc(10); state(0); chk_st(2'b01); chk_fl(7'h02);
    resonator_level_flag <= 1'b0; cyc(10); rd; sens(0); chk_d(12'hC00);
    state(0);
    $display("test self test done");
    sens(1); cyc(10); cmp("check mode", 16'h0001, {15'h0, cm});
    state(1); chk_st(2'b10); chk_fl(7'h7F);
    rd; sens(1); chk_d(12'hFFE);
    sens(0); cyc(10); cmp("check mode", 16'h0000, {15'h0, cm});
    cyc(300); rd; sens(0); state(0); chk_st(2'b01); chk_fl(7'h00);
    $display("test check mode done");
    repeat (3) corr();
    cyc(10); state(0); chk_fl(7'h00);
    corr(); cyc(10); state(0); chk_fl(7'h20);
    rstn <= 1'b0; cyc(5); rstn <= 1'b1; cyc(4);
    state(0); chk_st(2'b01); chk_fl(7'h00);
    $display("test accumulator and reset done");
    end_sim();
  end
endmodule // tb
